// >>> logic/apr_pin_routing.sv
// audio serial port pin routing and pad configuration, apb slave
// assumes pins are asynchronous to pclk; primary_dout and irq_req
// come from logic on pclk
//
// Notes on behaviour
// - pad drive field picks six drive modes
// - primary data input gated by enable bit
// - secondary frame sync source select bits 6-4
// - secondary bit clock source select bits 3-1
// - clock routing bit 0 reads zero
// - secondary data one source select bits 7-5
// - secondary data two source select bits 4-2
// - data routing bits 1-0 read zero
// - bit 7 makes record channel 1 digital
// - bit 6 makes record channel 2 digital
// - bit 5 swaps channel 1/2 latch edges
// - bit 4 swaps channel 3/4 latch edges
// - mic pair a data pin select
// - mic pair b data pin select
// - data-out pin function select, resets to 5
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/10ps
module apr_pin_routing (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [apr_pkg::ADDR_W-1:0] paddr,
	input wire logic [apr_pkg::DATA_W-1:0] pwdata,
	output logic pready,
	output logic [apr_pkg::DATA_W-1:0] prdata,
	output logic pslverr,
	input wire logic general_pin_one_i,
	input wire logic input_pin_2a_i,
	input wire logic input_pin_1a_i,
	input wire logic out_pad_i,
	input wire logic primary_fsync_i,
	input wire logic primary_bclk_i,
	input wire logic primary_din_i,
	input wire logic density_mod_clock_i,
	input wire logic primary_dout,
	input wire logic irq_req,
	output logic out_pad_o,
	output logic out_pad_oe,
	output logic out_pad_pull_up,
	output logic out_pad_pull_down,
	output logic primary_din_o,
	output logic secondary_fsync_o,
	output logic secondary_bclk_o,
	output logic secondary_din1_o,
	output logic secondary_din2_o,
	output logic record_ch1_digital,
	output logic record_ch2_digital,
	output logic [apr_pkg::NUM_MIC-1:0] mic_data,
	output logic [apr_pkg::NUM_MIC-1:0] mic_strobe
);
	localparam int NP = apr_pkg::NUM_PINS;

	// picks a routed pin; codes a field may not use fall to zero
	function automatic logic route_pick(
		input logic [2:0] code,
		input logic [NP-1:0] pins,
		input logic alt,
		input logic allow_dout
	);
		logic v;
		v = 1'b0;
		unique case (code)
			apr_pkg::SRC_GP1: v = pins[apr_pkg::PIN_GP1];
			apr_pkg::SRC_2A: v = pins[apr_pkg::PIN_2A];
			apr_pkg::SRC_1A: v = pins[apr_pkg::PIN_1A];
			apr_pkg::SRC_DOUT: v = allow_dout & pins[apr_pkg::PIN_DOUT];
			apr_pkg::SRC_PRIM: v = alt;
			default: v = 1'b0;
		endcase
		return v;
	endfunction : route_pick

	// ---------------- register file ----------------
	logic [apr_pkg::REG_W-1:0] pad_r, pad_nxt;
	logic [apr_pkg::REG_W-1:0] clk_r, clk_nxt;
	logic [apr_pkg::REG_W-1:0] din_r, din_nxt;
	logic [apr_pkg::REG_W-1:0] mic_r, mic_nxt;
	logic [apr_pkg::DATA_W-1:0] prdata_r, prdata_nxt;
	logic pslverr_r, pslverr_nxt;
	logic [apr_pkg::IDX_W-1:0] idx;
	logic hit;
	logic [apr_pkg::REG_W-1:0] rd_val;
	logic wr_en;
	logic [apr_pkg::REG_W-1:0] wbyte;

	assign idx = paddr[apr_pkg::ADDR_W-1:apr_pkg::BYTE_LSB];
	assign pready = psel & penable;
	assign wr_en = psel & penable & pwrite;
	assign wbyte = pwdata[apr_pkg::REG_W-1:0];

	always_comb begin
		hit = (paddr[apr_pkg::BYTE_LSB-1:0] == 2'h0);
		rd_val = 8'h00;
		unique case (idx)
			apr_pkg::IDX_PAD: rd_val = pad_r;
			apr_pkg::IDX_CLK: rd_val = clk_r & apr_pkg::MASK_CLK;
			apr_pkg::IDX_DIN: rd_val = din_r & apr_pkg::MASK_DIN;
			apr_pkg::IDX_MIC: rd_val = mic_r;
			default: hit = 1'b0;
		endcase
	end

	always_comb begin
		pad_nxt = pad_r;
		clk_nxt = clk_r;
		din_nxt = din_r;
		mic_nxt = mic_r;
		prdata_nxt = prdata_r;
		pslverr_nxt = pslverr_r;
		// answer is prepared in the setup cycle
		if (psel && !penable) begin
			prdata_nxt = hit ? {24'h000000, rd_val} : 32'h00000000;
			pslverr_nxt = !hit;
		end
		if (wr_en && hit) begin
			unique case (idx)
				apr_pkg::IDX_PAD: pad_nxt = wbyte & apr_pkg::MASK_PAD;
				apr_pkg::IDX_CLK: clk_nxt = wbyte & apr_pkg::MASK_CLK;
				apr_pkg::IDX_DIN: din_nxt = wbyte & apr_pkg::MASK_DIN;
				apr_pkg::IDX_MIC: mic_nxt = wbyte & apr_pkg::MASK_MIC;
				default: pad_nxt = pad_r;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pad_r <= apr_pkg::RST_PAD;
			clk_r <= apr_pkg::RST_CLK;
			din_r <= apr_pkg::RST_DIN;
			mic_r <= apr_pkg::RST_MIC;
			prdata_r <= 32'h00000000;
			pslverr_r <= 1'b0;
		end else begin
			pad_r <= pad_nxt;
			clk_r <= clk_nxt;
			din_r <= din_nxt;
			mic_r <= mic_nxt;
			prdata_r <= prdata_nxt;
			pslverr_r <= pslverr_nxt;
		end
	end

	assign prdata = prdata_r;
	assign pslverr = pslverr_r & pready;

	// ---------------- pin synchronisers ----------------
	logic [NP-1:0] pin_raw;
	logic [NP-1:0] meta_r, meta_nxt;
	logic [NP-1:0] pin_r, pin_nxt;
	logic mclk_prev_r, mclk_prev_nxt;

	assign pin_raw = {density_mod_clock_i, primary_din_i, primary_bclk_i,
		primary_fsync_i, out_pad_i, input_pin_1a_i, input_pin_2a_i,
		general_pin_one_i};

	always_comb begin
		meta_nxt = pin_raw;
		pin_nxt = meta_r;
		mclk_prev_nxt = pin_r[apr_pkg::PIN_MCLK];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_r <= '0;
			pin_r <= '0;
			mclk_prev_r <= 1'b0;
		end else begin
			meta_r <= meta_nxt;
			pin_r <= pin_nxt;
			mclk_prev_r <= mclk_prev_nxt;
		end
	end

	// ---------------- routing and mic capture ----------------
	logic mclk_rise, mclk_fall;
	logic pdin_gated;
	logic mic_a_pin, mic_b_pin;
	logic [apr_pkg::NUM_MIC-1:0] take;
	logic prim_r, prim_nxt;
	logic sfs_r, sfs_nxt;
	logic sbc_r, sbc_nxt;
	logic sd1_r, sd1_nxt;
	logic sd2_r, sd2_nxt;
	logic [apr_pkg::NUM_MIC-1:0] mic_data_r, mic_data_nxt;
	logic [apr_pkg::NUM_MIC-1:0] mic_stb_r, mic_stb_nxt;
	logic edge_a, edge_b;
	logic [1:0] src_a, src_b;

	assign mclk_rise = pin_r[apr_pkg::PIN_MCLK] & ~mclk_prev_r;
	assign mclk_fall = ~pin_r[apr_pkg::PIN_MCLK] & mclk_prev_r;
	assign edge_a = mic_r[apr_pkg::MIC_EDGE_A_BIT];
	assign edge_b = mic_r[apr_pkg::MIC_EDGE_B_BIT];
	assign src_a = mic_r[apr_pkg::MIC_SRC_A_MSB:apr_pkg::MIC_SRC_A_LSB];
	assign src_b = mic_r[apr_pkg::MIC_SRC_B_MSB:apr_pkg::MIC_SRC_B_LSB];

	always_comb begin
		pdin_gated = clk_r[apr_pkg::CLK_PEN_BIT]
			& pin_r[apr_pkg::PIN_PDIN];
		prim_nxt = pdin_gated;
		sfs_nxt = route_pick(
			clk_r[apr_pkg::CLK_FS_MSB:apr_pkg::CLK_FS_LSB], pin_r,
			pin_r[apr_pkg::PIN_PFS], 1'b0);
		sbc_nxt = route_pick(
			clk_r[apr_pkg::CLK_BC_MSB:apr_pkg::CLK_BC_LSB], pin_r,
			pin_r[apr_pkg::PIN_PBCLK], 1'b0);
		sd1_nxt = route_pick(
			din_r[apr_pkg::DIN_ONE_MSB:apr_pkg::DIN_ONE_LSB], pin_r,
			pdin_gated, 1'b1);
		sd2_nxt = route_pick(
			din_r[apr_pkg::DIN_TWO_MSB:apr_pkg::DIN_TWO_LSB], pin_r,
			pdin_gated, 1'b1);
		mic_a_pin = route_pick({1'b0, src_a}, pin_r, 1'b0, 1'b0);
		mic_b_pin = route_pick({1'b0, src_b}, pin_r, 1'b0, 1'b0);
		// edge bit 0: odd channel on falling, even on rising
		take[0] = (src_a != 2'h0) & (edge_a ? mclk_rise : mclk_fall);
		take[1] = (src_a != 2'h0) & (edge_a ? mclk_fall : mclk_rise);
		take[2] = (src_b != 2'h0) & (edge_b ? mclk_rise : mclk_fall);
		take[3] = (src_b != 2'h0) & (edge_b ? mclk_fall : mclk_rise);
		mic_stb_nxt = take;
		mic_data_nxt = mic_data_r;
		for (int i = 0; i < apr_pkg::NUM_MIC; i++) begin
			if (take[i]) begin
				mic_data_nxt[i] = (i < 2) ? mic_a_pin : mic_b_pin;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prim_r <= 1'b0;
			sfs_r <= 1'b0;
			sbc_r <= 1'b0;
			sd1_r <= 1'b0;
			sd2_r <= 1'b0;
			mic_data_r <= '0;
			mic_stb_r <= '0;
		end else begin
			prim_r <= prim_nxt;
			sfs_r <= sfs_nxt;
			sbc_r <= sbc_nxt;
			sd1_r <= sd1_nxt;
			sd2_r <= sd2_nxt;
			mic_data_r <= mic_data_nxt;
			mic_stb_r <= mic_stb_nxt;
		end
	end

	assign primary_din_o = prim_r;
	assign secondary_fsync_o = sfs_r;
	assign secondary_bclk_o = sbc_r;
	assign secondary_din1_o = sd1_r;
	assign secondary_din2_o = sd2_r;
	assign mic_data = mic_data_r;
	assign mic_strobe = mic_stb_r;
	assign record_ch1_digital = mic_r[apr_pkg::MIC_CH1_BIT];
	assign record_ch2_digital = mic_r[apr_pkg::MIC_CH2_BIT];

	// ---------------- data-out pad ----------------
	logic pad_val;
	logic pad_on;
	logic [2:0] drv;
	logic po_r, po_nxt;
	logic poe_r, poe_nxt;
	logic pu_r, pu_nxt;
	logic pd_r, pd_nxt;

	assign drv = pad_r[apr_pkg::PAD_DRV_MSB:apr_pkg::PAD_DRV_LSB];

	always_comb begin
		pad_on = 1'b1;
		pad_val = 1'b0;
		unique case (pad_r[apr_pkg::PAD_FN_MSB:apr_pkg::PAD_FN_LSB])
			apr_pkg::FN_GPO: pad_val = pad_r[apr_pkg::PAD_VAL_BIT];
			apr_pkg::FN_IRQ: pad_val = irq_req;
			apr_pkg::FN_MODCLK: pad_val = pin_r[apr_pkg::PIN_MCLK];
			apr_pkg::FN_PDOUT: pad_val = primary_dout;
			default: pad_on = 1'b0;
		endcase
		po_nxt = pad_val;
		poe_nxt = 1'b0;
		pu_nxt = 1'b0;
		pd_nxt = 1'b0;
		if (pad_on) begin
			unique case (drv)
				apr_pkg::DRV_PUSH: poe_nxt = 1'b1;
				apr_pkg::DRV_LO_WEAKHI: begin
					poe_nxt = ~pad_val;
					pu_nxt = pad_val;
				end
				apr_pkg::DRV_LO_HIZ: poe_nxt = ~pad_val;
				apr_pkg::DRV_WEAKLO_HI: begin
					poe_nxt = pad_val;
					pd_nxt = ~pad_val;
				end
				apr_pkg::DRV_HIZ_HI: poe_nxt = pad_val;
				default: poe_nxt = 1'b0;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			po_r <= 1'b0;
			poe_r <= 1'b0;
			pu_r <= 1'b0;
			pd_r <= 1'b0;
		end else begin
			po_r <= po_nxt;
			poe_r <= poe_nxt;
			pu_r <= pu_nxt;
			pd_r <= pd_nxt;
		end
	end

	assign out_pad_o = po_r;
	assign out_pad_oe = poe_r;
	assign out_pad_pull_up = pu_r;
	assign out_pad_pull_down = pd_r;
endmodule : apr_pin_routing

// >>> logic/apr_pkg.sv
// constants for the audio port pin routing block
// assumes an apb slave with 32-bit data on a 250 MHz clock
package apr_pkg;
	localparam int ADDR_W = 8;
	localparam int IDX_W = 6;
	localparam int DATA_W = 32;
	localparam int REG_W = 8;
	localparam int BYTE_LSB = 2;

	// register indices; byte address is four times the index
	localparam logic [IDX_W-1:0] IDX_PAD = 6'h10;
	localparam logic [IDX_W-1:0] IDX_CLK = 6'h11;
	localparam logic [IDX_W-1:0] IDX_DIN = 6'h12;
	localparam logic [IDX_W-1:0] IDX_MIC = 6'h13;

	localparam logic [REG_W-1:0] RST_PAD = 8'h52;
	localparam logic [REG_W-1:0] RST_CLK = 8'h80;
	localparam logic [REG_W-1:0] RST_DIN = 8'h00;
	localparam logic [REG_W-1:0] RST_MIC = 8'h00;

	// writable bits; reserved bits read as zero
	localparam logic [REG_W-1:0] MASK_PAD = 8'hFF;
	localparam logic [REG_W-1:0] MASK_CLK = 8'hFE;
	localparam logic [REG_W-1:0] MASK_DIN = 8'hFC;
	localparam logic [REG_W-1:0] MASK_MIC = 8'hFF;

	// field positions
	localparam int PAD_FN_LSB = 4;
	localparam int PAD_FN_MSB = 7;
	localparam int PAD_VAL_BIT = 3;
	localparam int PAD_DRV_LSB = 0;
	localparam int PAD_DRV_MSB = 2;
	localparam int CLK_PEN_BIT = 7;
	localparam int CLK_FS_LSB = 4;
	localparam int CLK_FS_MSB = 6;
	localparam int CLK_BC_LSB = 1;
	localparam int CLK_BC_MSB = 3;
	localparam int DIN_ONE_LSB = 5;
	localparam int DIN_ONE_MSB = 7;
	localparam int DIN_TWO_LSB = 2;
	localparam int DIN_TWO_MSB = 4;
	localparam int MIC_CH1_BIT = 7;
	localparam int MIC_CH2_BIT = 6;
	localparam int MIC_EDGE_A_BIT = 5;
	localparam int MIC_EDGE_B_BIT = 4;
	localparam int MIC_SRC_A_LSB = 2;
	localparam int MIC_SRC_A_MSB = 3;
	localparam int MIC_SRC_B_LSB = 0;
	localparam int MIC_SRC_B_MSB = 1;

	// pad drive modes
	localparam logic [2:0] DRV_HIZ = 3'h0;
	localparam logic [2:0] DRV_PUSH = 3'h1;
	localparam logic [2:0] DRV_LO_WEAKHI = 3'h2;
	localparam logic [2:0] DRV_LO_HIZ = 3'h3;
	localparam logic [2:0] DRV_WEAKLO_HI = 3'h4;
	localparam logic [2:0] DRV_HIZ_HI = 3'h5;

	// pad functions
	localparam logic [3:0] FN_OFF = 4'h0;
	localparam logic [3:0] FN_INPUT = 4'h1;
	localparam logic [3:0] FN_GPO = 4'h2;
	localparam logic [3:0] FN_IRQ = 4'h3;
	localparam logic [3:0] FN_MODCLK = 4'h4;
	localparam logic [3:0] FN_PDOUT = 4'h5;

	// source codes
	localparam logic [2:0] SRC_OFF = 3'h0;
	localparam logic [2:0] SRC_GP1 = 3'h1;
	localparam logic [2:0] SRC_2A = 3'h2;
	localparam logic [2:0] SRC_1A = 3'h3;
	localparam logic [2:0] SRC_DOUT = 3'h4;
	localparam logic [2:0] SRC_PRIM = 3'h5;

	// bit positions in the synchronised pin vector
	localparam int PIN_GP1 = 0;
	localparam int PIN_2A = 1;
	localparam int PIN_1A = 2;
	localparam int PIN_DOUT = 3;
	localparam int PIN_PFS = 4;
	localparam int PIN_PBCLK = 5;
	localparam int PIN_PDIN = 6;
	localparam int PIN_MCLK = 7;
	localparam int NUM_PINS = 8;
	localparam int NUM_MIC = 4;
endpackage : apr_pkg

// >>> bench/apr_pin_routing_sva.sv
// checker on the routing block ports
// assumes zero wait state apb and a slow mic clock
`timescale 1ns/10ps
module apr_pin_routing_sva (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [apr_pkg::ADDR_W-1:0] paddr,
	input wire logic pready,
	input wire logic [apr_pkg::DATA_W-1:0] prdata,
	input wire logic pslverr,
	input wire logic density_mod_clock_i,
	input wire logic [apr_pkg::NUM_MIC-1:0] mic_strobe
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_ready_on_access: assert property (psel && penable |-> pready)
		else $error("pready missing in access phase");
	a_ready_off_idle: assert property (!(psel && penable) |-> !pready)
		else $error("pready outside access phase");
	a_err_with_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	a_upper_data_zero: assert property (pready |-> prdata[31:8] == 24'h0)
		else $error("upper read data not zero");
	a_err_read_zero: assert property (pready && pslverr && !pwrite
		|-> prdata == 32'h0) else $error("refused read returned data");
	a_misalign_err: assert property (pready && paddr[1:0] != 2'h0
		|-> pslverr) else $error("misaligned access accepted");
	a_mapped_ok: assert property (pready && paddr inside
		{8'h40, 8'h44, 8'h48, 8'h4C} |-> !pslverr)
		else $error("mapped access refused");
	a_strobe_pulse: assert property (mic_strobe[0] |=> !mic_strobe[0])
		else $error("channel strobe longer than one cycle");
	a_pair_a_split: assert property (
		!(mic_strobe[0] && mic_strobe[1]))
		else $error("channels 1 and 2 latched on one edge");
	a_pair_b_split: assert property (
		!(mic_strobe[2] && mic_strobe[3]))
		else $error("channels 3 and 4 latched on one edge");
	a_strobe_edge: assert property (mic_strobe != 4'h0 |->
		$past(density_mod_clock_i, 2) != $past(density_mod_clock_i, 8))
		else $error("strobe without mic clock edge");
endmodule : apr_pin_routing_sva
bind apr_pin_routing apr_pin_routing_sva u_sva (.*);

// >>> bench/apr_mic_model.sv
// far side: one digital mic pair on a shared data pin
// assumes the clock stands low while disabled
`timescale 1ns/10ps
module apr_mic_model (
	input wire logic en,
	input wire logic dr,
	input wire logic df,
	output logic clk_o,
	output logic dat_o
);
	initial begin
		clk_o = 1'b0;
		dat_o = 1'b0;
		forever begin
			if (en) begin
				#40 clk_o = 1'b1;
				#40 dat_o = df;
				#40 clk_o = 1'b0;
				#40 dat_o = dr;
			end else begin
				// released line toggles, never holds a value
				#40 dat_o = ~dat_o;
			end
		end
	end
endmodule : apr_mic_model

// >>> bench/apr_pin_routing_bench.sv
// self-checking bench for the pin routing block
// assumes the design package is compiled first
`timescale 1ns/10ps
module apr_pin_routing_bench;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic gp1_r, p2a, p1a, pdo, pfs, pbc, pdi, pdout, irq, men, mclk, mdat;
	logic po, oe, pu, pd, pdin_o, sfs, sbc, sd1, sd2, rc1, rc2;
	logic [3:0] md, ms, x;
	logic [24:0] rows [6];
	int fail_count, checks, n;
	wire logic gp1 = men ? mdat : gp1_r;
	apr_mic_model u_mic (.en(men), .dr(1'b1), .df(1'b0), .clk_o(mclk),
		.dat_o(mdat));
	apr_pin_routing u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pready(pready), .prdata(prdata), .pslverr(pslverr),
		.general_pin_one_i(gp1), .input_pin_2a_i(p2a), .input_pin_1a_i(p1a),
		.out_pad_i(pdo), .primary_fsync_i(pfs), .primary_bclk_i(pbc),
		.primary_din_i(pdi), .density_mod_clock_i(mclk),
		.primary_dout(pdout), .irq_req(irq), .out_pad_o(po), .out_pad_oe(oe),
		.out_pad_pull_up(pu), .out_pad_pull_down(pd), .primary_din_o(pdin_o),
		.secondary_fsync_o(sfs), .secondary_bclk_o(sbc),
		.secondary_din1_o(sd1), .secondary_din2_o(sd2),
		.record_ch1_digital(rc1), .record_ch2_digital(rc2),
		.mic_data(md), .mic_strobe(ms));
	task stop_test();
		if (fail_count == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : stop_test
	task chk(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			fail_count++;
			$display("[FAIL] %0t got %h want %h", $time, g, e);
		end
	endtask : chk
	task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task rchk(input logic [7:0] a, input logic [7:0] e);
		apb(a, 1'b0, 32'h0);
		chk(rd, {24'h0, e});
	endtask : rchk
	task rst_chk();
		rchk(8'h40, 8'h52);
		rchk(8'h44, 8'h80);
		rchk(8'h48, 8'h00);
		rchk(8'h4C, 8'h00);
		chk({31'h0, oe}, 32'h1);
	endtask : rst_chk
	task pins(input logic [1:0] q);
		gp1_r <= q[0];
		p2a <= q[1];
		p1a <= ~q[0];
		pdo <= ~q[1];
		pfs <= ^q;
		pbc <= ~^q;
		pdi <= &q;
		repeat (6) @(posedge pclk);
	endtask : pins
	function automatic logic sel(logic [2:0] c, logic [1:0] q, logic ad,
		logic alt);
		case (c)
			3'h1: return q[0];
			3'h2: return q[1];
			3'h3: return ~q[0];
			3'h4: return ad & ~q[1];
			3'h5: return alt;
			default: return 1'b0;
		endcase
	endfunction : sel
	function automatic logic [2:0] drv(logic [2:0] d, logic v);
		case (d)
			3'h1: return 3'h4;
			3'h2: return {~v, v, 1'b0};
			3'h3: return {~v, 2'h0};
			3'h4: return {v, 1'b0, ~v};
			3'h5: return {v, 2'h0};
			default: return 3'h0;
		endcase
	endfunction : drv
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	initial begin
		#200000;
		fail_count++;
		$display("[FAIL] %0t watchdog expired", $time);
		stop_test();
	end
	initial begin
		{psel, penable, pwrite, gp1_r, p2a, p1a, pdo, pfs, pbc} = '0;
		{pdi, pdout, irq, men, presetn} = '0;
		paddr = 8'h0;
		pwdata = 32'h0;
		rows = '{25'h0402B2B, 25'h044FEFE, 25'h048FCFC, 25'h04CA5A5,
			25'h1501100, 25'h1411100};
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		rst_chk();
		foreach (rows[i]) begin
			apb(rows[i][23:16], 1'b1, {24'h0, rows[i][15:8]});
			apb(rows[i][23:16], 1'b0, 32'h0);
			chk(rd, {24'h0, rows[i][7:0]});
			chk({31'h0, er}, {31'h0, rows[i][24]});
		end
		for (int d = 0; d < 6; d++)
			for (int v = 0; v < 2; v++) begin
				apb(8'h40, 1'b1, {24'h0, 4'h2, v[0], d[2:0]});
				repeat (2) @(posedge pclk);
				x = {v[0], drv(d[2:0], v[0])};
				chk({28'h0, po, oe, pu, pd}, {28'h0, x});
			end
		for (int f = 3; f < 6; f++)
			for (int v = 0; v < 2; v++) begin
				irq <= v[0];
				pdout <= ~v[0];
				apb(8'h40, 1'b1, {24'h0, f[3:0], 4'h1});
				repeat (2) @(posedge pclk);
				x = {2'h0, (f == 3) ? v[0] : (f == 5 && !v[0]), 1'b1};
				chk({30'h0, po, oe}, {30'h0, x[1:0]});
			end
		for (int c = 0; c < 8; c++) begin
			apb(8'h44, 1'b1, {24'h0, 1'b1, c[2:0], c[2:0], 1'b0});
			apb(8'h48, 1'b1, {24'h0, c[2:0], c[2:0], 2'h0});
			for (int q = 0; q < 4; q++) begin
				pins(q[1:0]);
				x = {sel(c[2:0], q[1:0], 1'b0, ^q[1:0]),
					sel(c[2:0], q[1:0], 1'b0, ~^q[1:0]),
					sel(c[2:0], q[1:0], 1'b1, &q[1:0]),
					sel(c[2:0], q[1:0], 1'b1, &q[1:0])};
				chk({30'h0, sfs, sbc}, {30'h0, x[3:2]});
				chk({30'h0, sd1, sd2}, {30'h0, x[1:0]});
				chk({31'h0, pdin_o}, {31'h0, &q[1:0]});
			end
		end
		apb(8'h48, 1'b1, 32'hB4);
		apb(8'h44, 1'b1, 32'h0);
		pins(2'h3);
		chk({29'h0, pdin_o, sd1, sd2}, 32'h0);
		men <= 1'b1;
		repeat (50) @(posedge pclk);
		for (int e = 0; e < 2; e++) begin
			apb(8'h4C, 1'b1, {24'h0, 2'h3, e[0], e[0], 4'h5});
			repeat (8) @(posedge pclk);
			chk({30'h0, rc1, rc2}, 32'h3);
			for (int i = 0; i < 4; i++) begin
				n = 0;
				do begin
					@(posedge pclk);
					n++;
				end while (ms[i] !== 1'b1 && n < 200);
				chk({31'h0, ms[i]}, 32'h1);
				chk({31'h0, md[i]}, {31'h0, e[0] ^ i[0]});
			end
		end
		apb(8'h4C, 1'b1, 32'h0);
		repeat (4) @(posedge pclk);
		n = 0;
		repeat (100) begin
			@(posedge pclk);
			if (ms !== 4'h0) n++;
		end
		chk(n, 32'h0);
		chk({30'h0, rc1, rc2}, 32'h0);
		presetn <= 1'b0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		rst_chk();
		stop_test();
	end
endmodule : apr_pin_routing_bench
